// ==== logic/operand_cfg.svh ====
// Purpose: Constants for the flexible operand datapath
// Assumes: Included by bare name from the package and the datapath
// Notes:   Definitions only
`ifndef OPERAND_CFG_SVH
`define OPERAND_CFG_SVH

`define WORD_W        32
`define IMM_ROT_MAX   5'h18
`define IMM_BYTE_MAX  32'h000000FF
`define ADDR_STEP     32'h00000004
`define WORD_ZERO     32'h00000000
`define CARRY_RST     1'b0

`endif

// ==== logic/operand_pkg.sv ====
// Purpose: Types for the flexible operand datapath
// Assumes: operand_cfg.svh defines the word width
// Notes:   Request and result travel as packed structs
`include "operand_cfg.svh"

package operand_pkg;

  typedef enum logic [3:0] {
    OP_IDLE,
    OP_OPERAND,
    OP_MUL_LONG,
    OP_MAC_LONG,
    OP_SXT_BYTE,
    OP_SXT_HALF,
    OP_UFIELD,
    OP_SFIELD,
    OP_STORE_ASC,
    OP_STORE_DESC
  } op_t;

  typedef enum logic [1:0] {
    IMM_SHIFTED,
    IMM_REP_EVEN,
    IMM_REP_ODD,
    IMM_REP_ALL
  } imm_kind_t;

  typedef enum logic [2:0] {
    SH_LSL,
    SH_LSR,
    SH_ASR,
    SH_ROR,
    SH_RRX
  } shift_kind_t;

  typedef struct packed {
    logic                 valid;
    op_t                  op;
    logic                 set_flags;
    logic                 is_signed;
    logic                 use_imm;
    imm_kind_t            imm_kind;
    logic [7:0]           imm_byte;
    logic [4:0]           imm_rot;
    shift_kind_t          shift_kind;
    logic [5:0]           shift_len;
    logic [`WORD_W-1:0]   src_a;
    logic [`WORD_W-1:0]   src_b;
    logic [`WORD_W-1:0]   acc_lo;
    logic [`WORD_W-1:0]   acc_hi;
    logic [4:0]           field_lsb;
    logic [5:0]           field_width;
    logic [1:0]           rot_bytes;
    logic [4:0]           reg_count;
    logic                 writeback;
  } req_t;

  typedef struct packed {
    logic                 done;
    logic [`WORD_W-1:0]   value;
    logic [`WORD_W-1:0]   result_low_word;
    logic [`WORD_W-1:0]   result_high_word;
    logic                 long_we;
    logic                 carry_we;
    logic                 carry_out;
    logic [`WORD_W-1:0]   base_next;
    logic                 base_we;
  } rsp_t;

endpackage : operand_pkg

// ==== logic/flexible_operand_datapath.sv ====
// Purpose: Second-operand former, long multiply, extend, field and
//          block-store address slice of the core datapath
// Assumes: Request comes from decode on the same clock; carry_in is
//          the current carry flag held by the status logic
// Notes:   All arithmetic is one combinational stage, registered once;
//          held words stay until the next op that writes them
// How it works
// - Immediate: 8-bit value shifted left, staying inside the word.
// - Immediate: byte replicated in bytes 0/2, 1/3, or all four.
// - Flag-setting logic ops: shifted constant above 255 gives carry bit 31.
// - Any other immediate form leaves the carry untouched.
// - Shifts: right 1..32, left and rotate 1..31, rotate through carry.
// - No shift or left shift zero passes the source unchanged.
// - Shifted value used once; source register never written.
// - Flag-setting ops with shifted register take the shifter carry.
// - Long multiply gives a full 64-bit product, signed or unsigned.
// - Long multiply-accumulate adds product to the 64-bit pair.
// - Sign extend byte or halfword after optional byte rotate; no flags.
// - Field extract by lsb and width, zero or sign extended; no flags.
// - Block store ascending or descending, optional base writeback.
// - Arithmetic right shift fills with the source sign bit.
// - Rotate through carry puts old carry in bit 31, bit 0 out.
// - Shift length zero shifts nothing and leaves the carry; rotate through carry ignores the length.
// - Updated carry is the last bit shifted out.
`timescale 1ns/1ps
`default_nettype none
`include "operand_cfg.svh"

module flexible_operand_datapath #(
  parameter int WORD_W = `WORD_W
) (
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire operand_pkg::req_t req,
  input  wire logic              carry_in,
  output var  operand_pkg::rsp_t rsp
);

  // Expanded immediate and its carry
  logic [31:0] imm_value;
  logic        imm_carry_we;
  logic        imm_carry;

  // Shifted register operand and its carry
  logic [31:0] sh_value;
  logic        sh_carry_we;
  logic        sh_carry;

  // Other datapath results
  logic [63:0] long_value;
  logic [31:0] ext_value;
  logic [31:0] field_value;
  logic [31:0] store_start;
  logic [31:0] store_next;

  // Registered response
  operand_pkg::rsp_t rsp_ff;
  operand_pkg::rsp_t nxt_rsp;

  // Immediate expansion
  always_comb begin
    logic [4:0] rot;

    // Defaults: zero value, carry kept
    rot          = req.imm_rot;
    imm_value    = `WORD_ZERO;
    imm_carry_we = 1'b0;
    imm_carry    = carry_in;

    unique case (req.imm_kind)
      operand_pkg::IMM_SHIFTED: begin
        // Clamp so the byte never leaves the word
        if (rot > `IMM_ROT_MAX) begin
          rot = `IMM_ROT_MAX;                  // Keep byte in word
        end
        imm_value = {24'h000000, req.imm_byte} << rot;
        // Only a shifted byte above 255 moves the carry
        if (imm_value > `IMM_BYTE_MAX) begin
          imm_carry_we = 1'b1;
          imm_carry    = imm_value[31];
        end
      end
      operand_pkg::IMM_REP_EVEN: begin
        imm_value = {8'h00, req.imm_byte, 8'h00, req.imm_byte};
      end
      operand_pkg::IMM_REP_ODD: begin
        imm_value = {req.imm_byte, 8'h00, req.imm_byte, 8'h00};
      end
      operand_pkg::IMM_REP_ALL: begin
        imm_value = {4{req.imm_byte}};
      end
    endcase
  end

  // Register-operand barrel shifter; source is only read
  always_comb begin
    logic [32:0] wide;
    logic [63:0] twice;
    logic [5:0]  n;

    // Defaults: source passes untouched, carry kept
    n           = req.shift_len;
    wide        = 33'h000000000;
    twice       = 64'h0000000000000000;
    sh_value    = req.src_b;
    sh_carry_we = 1'b0;
    sh_carry    = carry_in;

    // One-bit rotate through the old carry
    if (req.shift_kind == operand_pkg::SH_RRX) begin
      sh_value    = {carry_in, req.src_b[31:1]};
      sh_carry_we = 1'b1;
      sh_carry    = req.src_b[0];
    end else if (n != 6'h00) begin
      // Any real shift writes the carry
      sh_carry_we = 1'b1;
      unique case (req.shift_kind)
        // Extra top bit catches the last bit out
        operand_pkg::SH_LSL: begin
          wide     = {1'b0, req.src_b} << n;
          sh_value = wide[31:0];
          sh_carry = wide[32];
        end
        // Guard bit below catches the last bit out
        operand_pkg::SH_LSR: begin
          wide     = {req.src_b, 1'b0} >> n;
          sh_value = wide[32:1];
          sh_carry = wide[0];
        end
        // Sign bit fills from the top
        operand_pkg::SH_ASR: begin
          wide     = 33'($signed({req.src_b, 1'b0}) >>> n);
          sh_value = wide[32:1];
          sh_carry = wide[0];
        end
        // Doubled word turns the shift into a rotate
        operand_pkg::SH_ROR: begin
          twice    = {req.src_b, req.src_b} >> n[4:0];
          sh_value = twice[31:0];
          sh_carry = twice[31];
        end
        default: begin
          sh_carry_we = 1'b0;
        end
      endcase
    end
  end

  // Long multiply and multiply-accumulate
  always_comb begin
    logic signed [65:0] prod;
    logic               ext_a;
    logic               ext_b;

    // Two guard bits let one signed multiplier serve both forms
    ext_a = req.is_signed & req.src_a[31];
    ext_b = req.is_signed & req.src_b[31];
    prod  = $signed({ext_a, ext_a, req.src_a}) *
            $signed({ext_b, ext_b, req.src_b});
    long_value = prod[63:0];

    // Accumulate wraps modulo the 64-bit pair
    if (req.op == operand_pkg::OP_MAC_LONG) begin
      long_value = prod[63:0] + {req.acc_hi, req.acc_lo};
    end
  end

  // Sign extension after byte rotate
  always_comb begin
    logic [63:0] twice;

    // Rotate right by whole bytes, then extend
    twice = {req.src_b, req.src_b} >> {req.rot_bytes, 3'h0};

    // Halfword or byte, sign bit copied up
    if (req.op == operand_pkg::OP_SXT_HALF) begin
      ext_value = {{16{twice[15]}}, twice[15:0]};
    end else begin
      ext_value = {{24{twice[7]}}, twice[7:0]};
    end
  end

  // Bit-field extraction by left then right shift
  always_comb begin
    logic [6:0]  top;
    logic [6:0]  left;
    logic [6:0]  right;
    logic        bad;
    logic [31:0] up;

    // Top edge of the field and the two shift counts
    top   = 7'(req.field_lsb) + 7'(req.field_width);
    left  = 7'h20 - top;
    right = 7'h20 - 7'(req.field_width);
    // Out of range yields zero, for the signed form too
    bad   = (top > 7'h20) || (req.field_width == 6'h00);
    if (bad) begin
      left  = 7'h00;
      right = 7'h00;
    end
    // Left shift drops bits above, right shift aligns
    up = req.src_b << left;
    if (bad) begin
      up = 32'h00000000;
    end
    if (req.op == operand_pkg::OP_SFIELD) begin
      field_value = 32'($signed(up) >>> right);
    end else begin
      field_value = up >> right;
    end
  end

  // Block-store addressing
  always_comb begin
    logic [31:0] span;

    // Bytes covered by the register list
    span = 32'(req.reg_count) * `ADDR_STEP;

    // Descending starts below the base; ascending at it
    if (req.op == operand_pkg::OP_STORE_DESC) begin
      store_start = req.src_a - span;
      store_next  = req.src_a - span;
    end else begin
      store_start = req.src_a;
      store_next  = req.src_a + span;
    end
  end

  // Response selection; all of the above settles in this cycle
  always_comb begin
    // Pulses default low; held words keep their value
    nxt_rsp                  = '0;
    nxt_rsp.result_low_word  = rsp_ff.result_low_word;
    nxt_rsp.result_high_word = rsp_ff.result_high_word;
    nxt_rsp.carry_out        = carry_in;       // Carry passes unless written
    nxt_rsp.base_next        = rsp_ff.base_next;

    if (req.valid) begin
      nxt_rsp.done = 1'b1;
      unique case (req.op)
        operand_pkg::OP_IDLE: begin
          nxt_rsp.done = 1'b0;
        end
        // Immediate or shifted register operand
        operand_pkg::OP_OPERAND: begin
          if (req.use_imm) begin
            nxt_rsp.value     = imm_value;
            nxt_rsp.carry_we  = req.set_flags & imm_carry_we;
            nxt_rsp.carry_out = imm_carry;
          end else begin
            nxt_rsp.value     = sh_value;
            nxt_rsp.carry_we  = req.set_flags & sh_carry_we;
            nxt_rsp.carry_out = sh_carry;
          end
        end
        // Both long forms write the word pair
        operand_pkg::OP_MUL_LONG,
        operand_pkg::OP_MAC_LONG: begin
          nxt_rsp.long_we          = 1'b1;
          nxt_rsp.result_low_word  = long_value[31:0];
          nxt_rsp.result_high_word = long_value[63:32];
        end
        // Extends never touch the carry
        operand_pkg::OP_SXT_BYTE,
        operand_pkg::OP_SXT_HALF: begin
          nxt_rsp.value = ext_value;
        end
        // Field extracts never touch the carry
        operand_pkg::OP_UFIELD,
        operand_pkg::OP_SFIELD: begin
          nxt_rsp.value = field_value;
        end
        // First address and new base
        operand_pkg::OP_STORE_ASC,
        operand_pkg::OP_STORE_DESC: begin
          nxt_rsp.value     = store_start;
          nxt_rsp.base_next = store_next;
          nxt_rsp.base_we   = req.writeback;
        end
        default: begin
          nxt_rsp.done = 1'b0;                 // Illegal op code ignored
        end
      endcase
    end
  end

  // Response register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Reset clears every answer field
      rsp_ff           <= '0;
      rsp_ff.carry_out <= `CARRY_RST;
    end else begin
      // Register the selected answer
      rsp_ff <= nxt_rsp;
    end
  end

  // Output straight from the register
  assign rsp = rsp_ff;

endmodule : flexible_operand_datapath

`default_nettype wire

// ==== test/flexible_operand_datapath_props.sv ====
// Purpose: Port assertions for the flexible operand datapath
// Assumes: Answers appear one edge after the request
// Notes:   Bound to the datapath at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module flexible_operand_datapath_props (
  input wire logic              clock,
  input wire logic              nrst,
  input wire operand_pkg::req_t req,
  input wire logic              carry_in,
  input wire operand_pkg::rsp_t rsp
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Request qualifiers
  wire logic go = req.valid && req.op != operand_pkg::OP_IDLE &&
                  req.op <= operand_pkg::OP_STORE_DESC;
  wire logic opr = go && req.op == operand_pkg::OP_OPERAND;
  wire logic shf = opr && !req.use_imm;

  AST_DONE:
    assert property (go |=> rsp.done)
    else $error("done missing after request");
  AST_IDLE:
    assert property (!go |=> !rsp.done && !rsp.carry_we)
    else $error("answer without request");
  AST_NOFLAG:
    assert property (go && req.op > operand_pkg::OP_OPERAND |=> !rsp.carry_we)
    else $error("carry written by a non-operand op");
  AST_REP:
    assert property (opr && req.use_imm &&
      req.imm_kind != operand_pkg::IMM_SHIFTED |=> !rsp.carry_we)
    else $error("replicated constant wrote carry");
  AST_PASS:
    assert property (shf && req.shift_kind != operand_pkg::SH_RRX &&
      req.shift_len == 6'h00 |=> !rsp.carry_we &&
      rsp.value == $past(req.src_b))
    else $error("zero shift altered operand or carry");
  AST_RRX:
    assert property (shf && req.set_flags &&
      req.shift_kind == operand_pkg::SH_RRX |=> rsp.carry_we &&
      rsp.carry_out == $past(req.src_b[0]) && rsp.value[31] == $past(carry_in))
    else $error("rotate through carry wrong");
  AST_LONG:
    assert property (go && (req.op == operand_pkg::OP_MUL_LONG ||
      req.op == operand_pkg::OP_MAC_LONG) |=> rsp.long_we)
    else $error("long result not written");
  AST_BASE:
    assert property (rsp.base_we |-> rsp.done && $past(req.writeback))
    else $error("base written without writeback");

  // Main scenarios reached
  cover property (rsp.long_we);
  cover property (rsp.base_we);
  cover property (rsp.carry_we && rsp.carry_out);
endmodule : flexible_operand_datapath_props

bind flexible_operand_datapath flexible_operand_datapath_props props (
  .clock(clock), .nrst(nrst), .req(req), .carry_in(carry_in), .rsp(rsp)
);
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the flexible operand datapath
// Assumes: One request per call, answer read one cycle later
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic              clock;
  logic              nrst;
  logic              carry_in;
  operand_pkg::req_t req;
  operand_pkg::rsp_t rsp;
  operand_pkg::req_t r;
  int                errors;
  int                checks;

  flexible_operand_datapath dut (
    .clock    (clock),
    .nrst     (nrst),
    .req      (req),
    .carry_in (carry_in),
    .rsp      (rsp)
  );

  // Core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic complete_run();
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask : chk

  // Fresh request of one kind
  task automatic start(operand_pkg::op_t o);
    r = '0;
    r.valid = 1'b1;
    r.op = o;
  endtask : start

  // Present r for one edge, then check done
  task automatic run(logic d);
    @(negedge clock);
    req = r;
    @(negedge clock);
    req = '0;
    chk("done", 64'(d), 64'(rsp.done));
  endtask : run

  task automatic t_imm();
    logic [31:0] rep [3] = '{32'h00A500A5, 32'hA500A500, 32'hA5A5A5A5};
    start(operand_pkg::OP_OPERAND);
    r.use_imm = 1'b1;
    r.set_flags = 1'b1;
    r.imm_byte = 8'h81;
    r.imm_rot = 5'h18;
    run(1'b1);
    chk("imm", 64'h81000000, 64'(rsp.value));
    chk("imm c", 64'h3, {62'h0, rsp.carry_we, rsp.carry_out});
    r.set_flags = 1'b0;
    run(1'b1);
    chk("imm nf", 64'h0, 64'(rsp.carry_we));
    r.set_flags = 1'b1;
    r.imm_rot = 5'h00;
    run(1'b1);
    chk("imm c", 64'h0, 64'(rsp.carry_we));
    r.imm_byte = 8'hA5;
    for (int k = 0; k < 3; k++) begin
      r.imm_kind = operand_pkg::imm_kind_t'(k + 1);
      run(1'b1);
      chk("rep", 64'(rep[k]), 64'(rsp.value));
      chk("rep c", 64'h0, 64'(rsp.carry_we));
    end
  endtask : t_imm

  task automatic sh(operand_pkg::shift_kind_t k, logic [5:0] n,
                    logic [31:0] v, logic c);
    start(operand_pkg::OP_OPERAND);
    r.set_flags = 1'b1;
    r.shift_kind = k;
    r.shift_len = n;
    r.src_b = 32'h80000005;
    run(1'b1);
    chk("shift", 64'(v), 64'(rsp.value));
    chk("shift c", 64'({n != 0 || k == operand_pkg::SH_RRX, c}),
        {62'h0, rsp.carry_we, rsp.carry_out});
  endtask : sh

  task automatic lng(operand_pkg::op_t o, logic s, logic [31:0] a,
                     logic [31:0] b, logic [63:0] acc, logic [63:0] e);
    start(o);
    r.is_signed = s;
    r.src_a = a;
    r.src_b = b;
    {r.acc_hi, r.acc_lo} = acc;
    run(1'b1);
    chk("long", e, {rsp.result_high_word, rsp.result_low_word});
    chk("long we", 64'h1, 64'(rsp.long_we));
  endtask : lng

  task automatic ext(operand_pkg::op_t o, logic [31:0] s, logic [4:0] l,
                     logic [5:0] w, logic [1:0] rb, logic [31:0] e);
    start(o);
    r.set_flags = 1'b1;
    r.src_b = s;
    r.field_lsb = l;
    r.field_width = w;
    r.rot_bytes = rb;
    run(1'b1);
    chk("ext", 64'(e), 64'(rsp.value));
    chk("ext c", 64'h0, 64'(rsp.carry_we));
  endtask : ext

  task automatic st(operand_pkg::op_t o, logic [31:0] b, logic [4:0] n,
                    logic wb, logic [31:0] v, logic [31:0] nb);
    start(o);
    r.src_a = b;
    r.reg_count = n;
    r.writeback = wb;
    run(1'b1);
    chk("addr", 64'(v), 64'(rsp.value));
    chk("base", {31'h0, wb, nb},
        {31'h0, rsp.base_we, rsp.base_next});
  endtask : st

  // Hang guard
  initial begin
    #20000;
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    checks = 0;
    nrst = 1'b0;
    carry_in = 1'b0;
    req = '0;
    r = '0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    chk("reset", 64'h0, 64'(|rsp));
    t_imm();
    sh(operand_pkg::SH_LSL, 6'h00, 32'h80000005, 1'b0);
    sh(operand_pkg::SH_LSL, 6'h1F, 32'h80000000, 1'b0);
    sh(operand_pkg::SH_LSR, 6'h01, 32'h40000002, 1'b1);
    sh(operand_pkg::SH_LSR, 6'h20, 32'h00000000, 1'b1);
    sh(operand_pkg::SH_ASR, 6'h01, 32'hC0000002, 1'b1);
    sh(operand_pkg::SH_ASR, 6'h20, 32'hFFFFFFFF, 1'b1);
    sh(operand_pkg::SH_ROR, 6'h1F, 32'h0000000B, 1'b0);
    sh(operand_pkg::SH_RRX, 6'h00, 32'h40000002, 1'b1);
    carry_in = 1'b1;
    sh(operand_pkg::SH_RRX, 6'h00, 32'hC0000002, 1'b1);
    sh(operand_pkg::SH_LSL, 6'h00, 32'h80000005, 1'b1);
    carry_in = 1'b0;
    lng(operand_pkg::OP_MUL_LONG, 1'b0, 32'hFFFFFFFF, 32'hFFFFFFFF, 64'h0,
        64'hFFFFFFFE00000001);
    lng(operand_pkg::OP_MAC_LONG, 1'b1, 32'hFFFFFFFF, 32'h2,
        64'h0000000100000000, 64'h00000000FFFFFFFE);
    lng(operand_pkg::OP_MAC_LONG, 1'b0, 32'hFFFFFFFF, 32'h2, 64'h2,
        64'h0000000200000000);
    lng(operand_pkg::OP_MUL_LONG, 1'b1, 32'hFFFFFFFF, 32'h2, 64'h0,
        64'hFFFFFFFFFFFFFFFE);
    ext(operand_pkg::OP_SXT_BYTE, 32'h00008000, 5'h0, 6'h0, 2'h1,
        32'hFFFFFF80);
    ext(operand_pkg::OP_SXT_HALF, 32'h12347FFF, 5'h0, 6'h0, 2'h0,
        32'h00007FFF);
    ext(operand_pkg::OP_UFIELD, 32'hF0F0F0F0, 5'h4, 6'h8, 2'h0,
        32'h0000000F);
    ext(operand_pkg::OP_SFIELD, 32'hF0F0F0F0, 5'h3, 6'h2, 2'h0,
        32'hFFFFFFFE);
    ext(operand_pkg::OP_SFIELD, 32'hF0000000, 5'h1C, 6'h8, 2'h0,
        32'h00000000);
    // Store bases are data addresses, never branch targets
    st(operand_pkg::OP_STORE_DESC, 32'h100, 5'h2, 1'b1, 32'hF8,
       32'hF8);
    st(operand_pkg::OP_STORE_ASC, 32'h200, 5'h3, 1'b0, 32'h200,
       32'h20C);
    st(operand_pkg::OP_STORE_ASC, 32'h200, 5'h3, 1'b1, 32'h200,
       32'h20C);
    r.valid = 1'b0;
    run(1'b0);
    @(negedge clock);
    nrst = 1'b0;
    @(negedge clock);
    nrst = 1'b1;
    chk("reset", 64'h0, 64'(|rsp));
    complete_run();
  end
endmodule : testbench
`default_nettype wire
